// >>> rtl/tmr_pkg.sv
// shared constants and carrier types for the temperature monitor register bank
// Overview of operation
// - first write byte loads the pointer
// - next bytes write pointer register; reads return it
// - pointer resets to local result address
// - result registers converter-owned, reset to zero
// - setup read 0x03, written 0x09, resets zero
// - setup bit 7 masks alert in alert mode
// - setup bit 6 selects standby, no conversions
// - serial access works unchanged in standby
// - outputs follow register writes during standby
// - setup bit 5 selects alert or second shutdown
// - setup bit 2 selects extended range
// - rate read 0x04, written 0x0a, divides oscillator
// - code doubles rate, 0x0a fastest, rest reserved
// - rate resets to 0x08
// - each interval converts both channels
// - above high or at/below low sets flag
// - shutdown low while result exceeds shutdown limit
// - second shutdown low while result exceeds high
// - one hysteresis register at 0x21, default ten
// - extended range adds 64 degrees offset
// - remote low byte holds two quarter bits
// - low byte read freezes high byte until read
// - shutdown releases at limit minus hysteresis
package tmr_pkg;
    // ==========================================================
    // register addresses
    localparam logic [7:0] ADDR_LOCAL_RES = 8'h00;
    localparam logic [7:0] ADDR_REMOTE_HI = 8'h01;
    localparam logic [7:0] ADDR_STATUS    = 8'h02;
    localparam logic [7:0] ADDR_SETUP_RD  = 8'h03;
    localparam logic [7:0] ADDR_RATE_RD   = 8'h04;
    localparam logic [7:0] ADDR_LIM_RD    = 8'h05;
    localparam logic [7:0] ADDR_SETUP_WR  = 8'h09;
    localparam logic [7:0] ADDR_RATE_WR   = 8'h0a;
    localparam logic [7:0] ADDR_LIM_WR    = 8'h0b;
    localparam logic [7:0] ADDR_REMOTE_LO = 8'h10;
    localparam logic [7:0] ADDR_LSHUT     = 8'h1e;
    localparam logic [7:0] ADDR_RSHUT     = 8'h1f;
    localparam logic [7:0] ADDR_HYST      = 8'h21;
    // ==========================================================
    // fields and reset values
    localparam int         SETUP_MASK_BIT  = 7;
    localparam int         SETUP_STBY_BIT  = 6;
    localparam int         SETUP_FUNC_BIT  = 5;
    localparam int         SETUP_RANGE_BIT = 2;
    localparam logic [7:0] SETUP_USED      = 8'he4;
    localparam logic [7:0] SETUP_RESET     = 8'h00;
    localparam logic [7:0] RATE_RESET      = 8'h08;
    localparam logic [3:0] RATE_CODE_MAX   = 4'ha;
    localparam logic [7:0] PTR_RESET       = 8'h00;
    localparam logic [7:0] RES_RESET       = 8'h00;
    localparam logic [7:0] HYST_RESET      = 8'h0a;
    localparam int         LIM_LHIGH = 0;
    localparam int         LIM_LLOW  = 1;
    localparam int         LIM_RHIGH = 2;
    localparam int         LIM_RLOW  = 3;
    localparam int         LIM_LSHUT = 4;
    localparam int         LIM_RSHUT = 5;
    localparam int         LIM_COUNT = 6;
    localparam logic [7:0] LIM_RESET [LIM_COUNT] = '{8'h55, 8'h00, 8'h55, 8'h00, 8'h64, 8'h64};
    // extended range offset: 64 degrees in quarter steps
    localparam logic signed [11:0] EXT_OFFSET_QD = 12'sh100;
    localparam logic signed [11:0] BIN_MAX_QD    = 12'sh1ff;
    localparam logic signed [11:0] EXT_MAX_QD    = 12'sh3ff;
    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS     = 50;
    localparam int SLOWEST_PERIOD_S  = 16;
    localparam int RATE_DIV_MAX      = 1024;
    localparam int BASE_CYCLES       =
        int'(longint'(SLOWEST_PERIOD_S) * 64'd1000000000 / (RATE_DIV_MAX * CLK_PERIOD_NS));
    // target address: arbitrary value
    localparam logic [6:0] DEV_ADDR  = 7'h2a;
    // ==========================================================
    // carriers
    typedef struct packed {
        logic signed [10:0] local_qd;
        logic signed [10:0] remote_qd;
    } tmr_meas_type;
    typedef struct packed {
        logic       ptr_wr;
        logic       data_wr;
        logic       rd_load;
        logic [7:0] data;
    } tmr_evt_type;
endpackage : tmr_pkg

// >>> rtl/tmr_rate_timer.sv
// conversion interval timer
`timescale 1ns/1ps
`default_nettype none
module tmr_rate_timer import tmr_pkg::*; #(
    parameter int BASE = BASE_CYCLES
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // control
    input  wire logic       run,
    input  wire logic [3:0] code,
    // request
    output logic            conv_req
);
    localparam int PW = $clog2(BASE);
    generate
        if (BASE < 2) begin : g_chk
            $error("BASE too small");
        end
    endgenerate
    logic [PW-1:0] pre_q;
    logic [9:0]    div_q;
    logic [9:0]    last;
    logic          tick;
    // reserved codes run at the fastest rate
    always_comb begin
        last = 10'((11'd1 << (RATE_CODE_MAX - ((code > RATE_CODE_MAX) ? RATE_CODE_MAX : code))) - 11'd1);
        tick = (pre_q == PW'(BASE - 1));
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_q    <= '0;
            div_q    <= '0;
            conv_req <= 1'b0;
        end else if (!run) begin
            pre_q    <= '0;
            div_q    <= '0;
            conv_req <= 1'b0;
        end else begin
            pre_q    <= tick ? '0 : PW'(pre_q + 1'b1);
            conv_req <= tick && (div_q >= last);
            if (tick) begin
                div_q <= (div_q >= last) ? '0 : 10'(div_q + 1'b1);
            end
        end
    end
endmodule : tmr_rate_timer
`default_nettype wire

// >>> rtl/tmr_i2c_target.sv
// serial two-wire target: byte events toward the register bank
`timescale 1ns/1ps
`default_nettype none
module tmr_i2c_target import tmr_pkg::*; (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // bus pins
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_oe,
    // bank side
    input  wire logic [7:0] rd_data,
    output tmr_evt_type     evt
);
    typedef enum {ST_IDLE, ST_ADDR, ST_AACK, ST_WR, ST_WACK, ST_RD, ST_RACK} tmr_st_type;
    tmr_st_type st_q;
    logic [2:0] scl_q, sda_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q;
    logic       first_q, rw_q;
    logic       rise, fall, start, stop;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_q <= 3'h7;
            sda_q <= 3'h7;
        end else begin
            scl_q <= {scl_q[1:0], scl_i};
            sda_q <= {sda_q[1:0], sda_i};
        end
    end
    assign rise  = scl_q[1] & ~scl_q[2];
    assign fall  = ~scl_q[1] & scl_q[2];
    assign start = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
    assign stop  = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ST_IDLE;
            cnt_q <= '0;
            sh_q <= '0;
            first_q <= 1'b0;
            rw_q <= 1'b0;
            sda_oe <= 1'b0;
            evt <= '0;
        end else begin
            evt <= '0;
            if (start || stop) begin
                st_q   <= start ? ST_ADDR : ST_IDLE;
                cnt_q  <= '0;
                sda_oe <= 1'b0;
            end else if (rise && (st_q == ST_ADDR || st_q == ST_WR)) begin
                sh_q  <= {sh_q[6:0], sda_q[1]};
                cnt_q <= 4'(cnt_q + 1'b1);
            end else if (rise && st_q == ST_RD) begin
                cnt_q <= 4'(cnt_q + 1'b1);
            end else if (rise && st_q == ST_RACK) begin
                if (sda_q[1]) st_q <= ST_IDLE;
            end else if (fall) begin
                case (st_q)
                    ST_ADDR: if (cnt_q == 4'h8) begin
                        if (sh_q[7:1] == DEV_ADDR) begin
                            sda_oe <= 1'b1;
                            rw_q   <= sh_q[0];
                            st_q   <= ST_AACK;
                        end else st_q <= ST_IDLE;
                    end
                    ST_AACK, ST_RACK: begin
                        cnt_q <= '0;
                        if (rw_q) begin
                            sh_q        <= rd_data;
                            sda_oe      <= ~rd_data[7];
                            evt.rd_load <= 1'b1;
                            st_q        <= ST_RD;
                        end else begin
                            sda_oe  <= 1'b0;
                            first_q <= 1'b1;
                            st_q    <= ST_WR;
                        end
                    end
                    ST_WR: if (cnt_q == 4'h8) begin
                        sda_oe      <= 1'b1;
                        evt.ptr_wr  <= first_q;
                        evt.data_wr <= ~first_q;
                        evt.data    <= sh_q;
                        first_q     <= 1'b0;
                        st_q        <= ST_WACK;
                    end
                    ST_WACK: begin
                        sda_oe <= 1'b0;
                        cnt_q  <= '0;
                        st_q   <= ST_WR;
                    end
                    ST_RD: if (cnt_q == 4'h8) begin
                        sda_oe <= 1'b0;
                        st_q   <= ST_RACK;
                    end else begin
                        sda_oe <= ~sh_q[6];
                        sh_q   <= {sh_q[6:0], 1'b0};
                    end
                    default: st_q <= ST_IDLE;
                endcase
            end
        end
    end
endmodule : tmr_i2c_target
`default_nettype wire

// >>> rtl/tmr_register_bank.sv
// register bank, result formatting and limit comparison of the temperature monitor
`timescale 1ns/1ps
`default_nettype none
module tmr_register_bank import tmr_pkg::*; #(
    parameter int BASE = BASE_CYCLES
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // serial bus pins, open drain
    input  wire logic         scl_i,
    input  wire logic         sda_i,
    output logic              sda_oe,
    // converter
    output logic              conv_req,
    input  wire logic         meas_valid,
    input  wire tmr_meas_type meas,
    // alarm pins, active low
    output logic              overtemp_shutdown_n,
    output logic              shared_alert_pin_n
);
    // ==========================================================
    // state
    logic [7:0]  ptr_q;
    logic [7:0]  local_q, remote_hi_q, remote_lo_q;
    logic [7:0]  setup_q, rate_q, hyst_q;
    logic [7:0]  lim_q [LIM_COUNT];
    logic        lock_q;
    logic [3:0]  flag_q;
    logic        lshut_q, rshut_q, lsec_q, rsec_q;
    logic [7:0]  rd_data;
    tmr_evt_type evt;
    logic        lhigh, llow, rhigh, rlow, alert;
    logic [9:0]  enc_local, enc_remote;
    logic        func_sel, mask_bit, ext_range, standby;

    assign mask_bit  = setup_q[SETUP_MASK_BIT];
    assign standby   = setup_q[SETUP_STBY_BIT];
    assign func_sel  = setup_q[SETUP_FUNC_BIT];
    assign ext_range = setup_q[SETUP_RANGE_BIT];

    // ==========================================================
    // helpers
    function automatic logic [9:0] encode_temp(input logic signed [10:0] qd, input logic ext);
        logic signed [11:0] v;
        logic signed [11:0] top;
        v   = ext ? 12'({qd[10], qd} + EXT_OFFSET_QD) : {qd[10], qd};
        top = ext ? EXT_MAX_QD : BIN_MAX_QD;
        if (v < 12'sd0) begin
            encode_temp = '0;
        end else if (v > top) begin
            encode_temp = 10'(top);
        end else begin
            encode_temp = v[9:0];
        end
    endfunction : encode_temp

    // set above limit, release only at limit minus hysteresis
    function automatic logic shut_next(input logic st, input logic [7:0] res,
                                       input logic [7:0] lim, input logic [7:0] hyst);
        if (res > lim) begin
            shut_next = 1'b1;
        end else if ({1'b0, res} + {1'b0, hyst} <= {1'b0, lim}) begin
            shut_next = 1'b0;
        end else begin
            shut_next = st;
        end
    endfunction : shut_next

    // ==========================================================
    // serial target and interval timer
    tmr_i2c_target u_i2c (
        .clk     (clk),
        .rst_n   (rst_n),
        .scl_i   (scl_i),
        .sda_i   (sda_i),
        .sda_oe  (sda_oe),
        .rd_data (rd_data),
        .evt     (evt)
    );

    tmr_rate_timer #(.BASE(BASE)) u_timer (
        .clk      (clk),
        .rst_n    (rst_n),
        .run      (~standby),
        .code     (rate_q[3:0]),
        .conv_req (conv_req)
    );

    // ==========================================================
    // pointer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr_q <= PTR_RESET;
        end else if (evt.ptr_wr) begin
            ptr_q <= evt.data;
        end
    end

    // ==========================================================
    // writable registers; bus stays live in standby
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            setup_q <= SETUP_RESET;
            rate_q  <= RATE_RESET;
            hyst_q  <= HYST_RESET;
            for (int i = 0; i < LIM_COUNT; i++) begin
                lim_q[i] <= LIM_RESET[i];
            end
        end else if (evt.data_wr) begin
            case (ptr_q)
                ADDR_SETUP_WR: setup_q <= evt.data & SETUP_USED;
                ADDR_RATE_WR:  rate_q  <= evt.data;
                ADDR_HYST:     hyst_q  <= evt.data;
                ADDR_LSHUT:    lim_q[LIM_LSHUT] <= evt.data;
                ADDR_RSHUT:    lim_q[LIM_RSHUT] <= evt.data;
                default: begin
                    for (int i = 0; i < 4; i++) begin
                        if (ptr_q == 8'(ADDR_LIM_WR + i)) lim_q[i] <= evt.data;
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // converter results; bus writes never reach them
    assign enc_local  = encode_temp(meas.local_qd, ext_range);
    assign enc_remote = encode_temp(meas.remote_qd, ext_range);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            local_q     <= RES_RESET;
            remote_hi_q <= RES_RESET;
            remote_lo_q <= RES_RESET;
        end else if (meas_valid) begin
            local_q     <= enc_local[9:2];
            remote_lo_q <= {enc_remote[1:0], 6'h00};
            if (!lock_q) begin
                remote_hi_q <= enc_remote[9:2];
            end
        end
    end

    // low byte read freezes the high byte until it is read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_q <= 1'b0;
        end else if (evt.rd_load && ptr_q == ADDR_REMOTE_LO) begin
            lock_q <= 1'b1;
        end else if (evt.rd_load && ptr_q == ADDR_REMOTE_HI) begin
            lock_q <= 1'b0;
        end
    end

    // ==========================================================
    // read path
    always_comb begin
        case (ptr_q)
            ADDR_LOCAL_RES: rd_data = local_q;
            ADDR_REMOTE_HI: rd_data = remote_hi_q;
            ADDR_REMOTE_LO: rd_data = remote_lo_q;
            ADDR_STATUS:    rd_data = {1'b0, flag_q, 1'b0, rshut_q, lshut_q};
            ADDR_SETUP_RD:  rd_data = setup_q;
            ADDR_RATE_RD:   rd_data = rate_q;
            ADDR_HYST:      rd_data = hyst_q;
            ADDR_LSHUT:     rd_data = lim_q[LIM_LSHUT];
            ADDR_RSHUT:     rd_data = lim_q[LIM_RSHUT];
            default: begin
                rd_data = 8'h00;
                for (int i = 0; i < 4; i++) begin
                    if (ptr_q == 8'(ADDR_LIM_RD + i)) rd_data = lim_q[i];
                end
            end
        endcase
    end

    // ==========================================================
    // limit comparison, continuous so writes act at once
    always_comb begin
        lhigh = local_q > lim_q[LIM_LHIGH];
        llow  = local_q <= lim_q[LIM_LLOW];
        rhigh = remote_hi_q > lim_q[LIM_RHIGH];
        rlow  = remote_hi_q <= lim_q[LIM_RLOW];
    end

    // flags stick in alert mode; a status read clears those whose cause is gone
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag_q <= '0;
        end else if (func_sel) begin
            flag_q <= {lhigh, llow, rhigh, rlow};
        end else if (evt.rd_load && ptr_q == ADDR_STATUS) begin
            flag_q <= {lhigh, llow, rhigh, rlow}; // set wins over clear
        end else begin
            flag_q <= flag_q | {lhigh, llow, rhigh, rlow};
        end
    end

    assign alert = |flag_q && !mask_bit;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lshut_q <= 1'b0;
            rshut_q <= 1'b0;
            lsec_q  <= 1'b0;
            rsec_q  <= 1'b0;
        end else begin
            lshut_q <= shut_next(lshut_q, local_q, lim_q[LIM_LSHUT], hyst_q);
            rshut_q <= shut_next(rshut_q, remote_hi_q, lim_q[LIM_RSHUT], hyst_q);
            lsec_q  <= shut_next(lsec_q, local_q, lim_q[LIM_LHIGH], hyst_q);
            rsec_q  <= shut_next(rsec_q, remote_hi_q, lim_q[LIM_RHIGH], hyst_q);
        end
    end

    // pins registered; alarms stay live in standby
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            overtemp_shutdown_n <= 1'b1;
            shared_alert_pin_n  <= 1'b1;
        end else begin
            overtemp_shutdown_n <= ~(lshut_q | rshut_q);
            shared_alert_pin_n  <= func_sel ? ~(lsec_q | rsec_q) : ~alert;
        end
    end

    // ==========================================================
    // checks
    a_ptr_load: assert property (@(posedge clk) disable iff (!rst_n)
        evt.ptr_wr |=> ptr_q == $past(evt.data))
        else $error("pointer not loaded");

    a_setup_write: assert property (@(posedge clk) disable iff (!rst_n)
        evt.data_wr && ptr_q == ADDR_SETUP_WR |=> setup_q == ($past(evt.data) & SETUP_USED))
        else $error("setup write lost");

    a_result_guard: assert property (@(posedge clk) disable iff (!rst_n)
        evt.data_wr && !meas_valid |=> $stable(local_q) && $stable(remote_lo_q))
        else $error("bus write changed a result");

    a_standby_quiet: assert property (@(posedge clk) disable iff (!rst_n)
        standby && $past(standby) |-> !conv_req)
        else $error("conversion requested in standby");

    sequence s_lock_read;
        evt.rd_load && ptr_q == ADDR_REMOTE_LO;
    endsequence
    a_high_frozen: assert property (@(posedge clk) disable iff (!rst_n)
        s_lock_read ##1 (!evt.rd_load [*2]) |-> $stable(remote_hi_q))
        else $error("remote high byte changed while frozen");

    a_shut_assert: assert property (@(posedge clk) disable iff (!rst_n)
        local_q > lim_q[LIM_LSHUT] |-> ##2 !overtemp_shutdown_n)
        else $error("shutdown not asserted");

    a_shut_release: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(overtemp_shutdown_n) |->
            ({1'b0, $past(local_q, 2)} + {1'b0, $past(hyst_q, 2)} <= {1'b0, $past(lim_q[LIM_LSHUT], 2)}))
        else $error("shutdown released inside hysteresis");

    a_second_shut: assert property (@(posedge clk) disable iff (!rst_n)
        func_sel && $past(func_sel) && remote_hi_q > lim_q[LIM_RHIGH] |-> ##2 !shared_alert_pin_n)
        else $error("second shutdown not asserted");

    a_alert_mask: assert property (@(posedge clk) disable iff (!rst_n)
        !func_sel && mask_bit |=> shared_alert_pin_n)
        else $error("masked alert drove pin");
endmodule : tmr_register_bank
`default_nettype wire

// >>> testbench/tmr_host_model.sv
// bus controller model driving the two-wire host side
`timescale 1ns/1ps
`default_nettype none
module tmr_host_model import tmr_pkg::*; (
    // clock
    input  wire logic  clk,
    // bus, data line open drain
    input  wire logic  sda_oe,
    output logic       scl,
    output wire logic  sda,
    // read result
    output logic [7:0] rd_q,
    output logic       rd_done
);
    logic sda_rel;
    // pull-up: a released line reads high, never a held-over value
    assign sda = sda_rel & ~sda_oe;
    initial begin
        scl = 1'b1;
        sda_rel = 1'b1;
        rd_q = 8'h00;
        rd_done = 1'b0;
    end
    // ==========================================================
    // bus primitives, one bit takes eight clocks
    task automatic w(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : w
    task automatic bitx(input logic b, output logic r);
        sda_rel = b;
        w(2);
        scl = 1'b1;
        w(2);
        r = sda;
        w(2);
        scl = 1'b0;
        w(2);
    endtask : bitx
    task automatic tx(input logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(d[i], r);
        bitx(1'b1, r);
    endtask : tx
    task automatic start(input logic rw);
        sda_rel = 1'b0;
        w(2);
        scl = 1'b0;
        w(2);
        tx({DEV_ADDR, rw});
    endtask : start
    task automatic stop;
        sda_rel = 1'b0;
        w(2);
        scl = 1'b1;
        w(2);
        sda_rel = 1'b1;
        w(4);
    endtask : stop
    // ==========================================================
    // transfers
    task automatic wr(input logic [7:0] p, input logic [7:0] d, input logic has_d);
        start(1'b0);
        tx(p);
        if (has_d) tx(d);
        stop();
    endtask : wr
    task automatic rd;
        logic [7:0] q;
        logic       r;
        start(1'b1);
        for (int i = 7; i >= 0; i--) bitx(1'b1, q[i]);
        bitx(1'b1, r);
        stop();
        rd_q = q;
        rd_done = 1'b1;
        w(1);
        rd_done = 1'b0;
    endtask : rd
endmodule : tmr_host_model
`default_nettype wire

// >>> testbench/test_tmr_register_bank.sv
// self-checking bench for the temperature monitor register bank
`timescale 1ns/1ps
`default_nettype none
module test_tmr_register_bank import tmr_pkg::*; ;
    localparam int WD_CYC = 60000;
    logic         clk = 1'b0;
    logic         rst_n = 1'b0;
    logic         meas_valid = 1'b0;
    tmr_meas_type meas = '0;
    wire          scl, sda, sda_oe, conv_req, shut_n, alert_n, rd_done;
    wire [7:0]    rd_q;
    int           miscompares = 0;
    int           tests_run = 0;
    int           n_req = 0;
    int           cyc = 0;
    int           last = 0;
    int           gap_c = 0;
    int           k = 0;
    logic [3:0]   c;
    logic [7:0]   exq[$];
    tmr_register_bank #(.BASE(8)) tmr_register_bank_inst (
        .clk(clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda), .sda_oe(sda_oe),
        .conv_req(conv_req), .meas_valid(meas_valid), .meas(meas),
        .overtemp_shutdown_n(shut_n), .shared_alert_pin_n(alert_n));
    tmr_host_model tmr_host_model_inst (.clk(clk), .sda_oe(sda_oe), .scl(scl),
        .sda(sda), .rd_q(rd_q), .rd_done(rd_done));
    always #25 clk = ~clk;
    // ==========================================================
    // helpers
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        tests_run++;
        if (s !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic w(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : w
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        tmr_host_model_inst.wr(p, d, 1'b1);
    endtask : wr
    task automatic rd(input logic [7:0] p, input logic [7:0] e);
        exq.push_back(e);
        tmr_host_model_inst.wr(p, 8'h00, 1'b0);
        tmr_host_model_inst.rd();
    endtask : rd
    task automatic conv(input int l, input int r);
        meas.local_qd = 11'(l);
        meas.remote_qd = 11'(r);
        meas_valid = 1'b1;
        w(1);
        meas_valid = 1'b0;
        w(4);
    endtask : conv
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_of_test
    // ==========================================================
    // output watcher: request spacing and read results
    always @(posedge clk) begin
        cyc++;
        if (conv_req === 1'b1) begin
            gap_c = cyc - last;
            last = cyc;
            n_req++;
        end
        if (rd_done === 1'b1 && exq.size() > 0) chk("read", rd_q, exq.pop_front());
    end
    initial begin
        repeat (WD_CYC) @(posedge clk);
        miscompares++;
        $display("Error watchdog expired");
        end_of_test();
    end
    // ==========================================================
    // main sequence
    initial begin
        void'($urandom(21656));
        w(8);
        rst_n = 1'b1;
        w(4);
        exq.push_back(8'h00);
        tmr_host_model_inst.rd();
        rd(ADDR_SETUP_RD, 8'h00);
        rd(ADDR_RATE_RD, 8'h08);
        rd(ADDR_HYST, 8'h0a);
        wr(ADDR_LOCAL_RES, 8'hff);
        rd(ADDR_LOCAL_RES, 8'h00);
        chk("alert", alert_n, 1'b0);
        $display("reset test done");
        wr(ADDR_SETUP_WR, 8'h80);
        w(4);
        chk("alert", alert_n, 1'b1);
        wr(ADDR_SETUP_WR, 8'h20);
        conv(101 * 4, 203);
        chk("shut", shut_n, 1'b0);
        chk("alert", alert_n, 1'b0);
        rd(ADDR_REMOTE_LO, 8'hc0);
        conv(95 * 4, 240);
        chk("shut", shut_n, 1'b0);
        rd(ADDR_REMOTE_HI, 8'h32);
        conv(90 * 4, 360);
        chk("shut", shut_n, 1'b1);
        chk("alert", alert_n, 1'b0);
        rd(ADDR_REMOTE_HI, 8'h5a);
        $display("alarm test done");
        wr(ADDR_SETUP_WR, 8'h60);
        k = n_req;
        wr(ADDR_LSHUT, 8'h50);
        w(4);
        chk("shut", shut_n, 1'b0);
        rd(ADDR_SETUP_RD, 8'h60);
        chk("conv", 16'(n_req - k), 16'h0000);
        $display("standby test done");
        wr(ADDR_SETUP_WR, 8'h00);
        for (int i = 0; i < 3; i++) begin
            c = (i == 0) ? 4'ha : ((i == 1) ? 4'($urandom_range(9, 1)) : 4'h0);
            wr(ADDR_RATE_WR, {4'h0, c});
            w((3 << (13 - c)) + 64);
            chk("gap", 16'(gap_c), 16'(8 << (10 - c)));
            rd(ADDR_RATE_RD, {4'h0, c});
        end
        $display("rate test done");
        wr(ADDR_SETUP_WR, 8'h04);
        wr(ADDR_LSHUT, 8'ha4);
        conv(10 * 4, 203);
        rd(ADDR_LOCAL_RES, 8'h4a);
        rd(ADDR_REMOTE_HI, 8'h72);
        $display("range test done");
        w(4);
        end_of_test();
    end
endmodule : test_tmr_register_bank
`default_nettype wire
